// ===== mag_pkg.sv
package mag_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	typedef struct packed {
		logic awvalid;
		logic [7:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [7:0] araddr;
		logic rready;
	} mag_axi_req_s;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} mag_axi_rsp_s;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_DELAY = 8'h04;
	localparam logic [7:0] OFS_GATE = 8'h08;
	localparam logic [7:0] OFS_CMD = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_COUNT = 8'h14;
	localparam logic [7:0] OFS_GTIME = 8'h18;

	// qualifier edge selection
	localparam logic [1:0] QUAL_OFF = 2'h0;
	localparam logic [1:0] QUAL_RISE = 2'h1;
	localparam logic [1:0] QUAL_FALL = 2'h2;

	// measuring functions
	localparam logic [2:0] FN_FREQ = 3'h0;
	localparam logic [2:0] FN_PERIOD = 3'h1;
	localparam logic [2:0] FN_PWIDTH = 3'h2;
	localparam logic [2:0] FN_DUTY = 3'h3;
	localparam logic [2:0] FN_BURST = 3'h4;
	localparam logic [2:0] FN_PRF = 3'h5;

	typedef struct packed {
		logic [2:0] func;
		logic bus_trig_en;
		logic freeze;
		logic single;
		logic delay_en;
		logic [1:0] stop_qualify_setting;
		logic [1:0] start_qualify_setting;
	} mag_ctrl_s;

	localparam mag_ctrl_s CTRL_RESET = '{FN_FREQ, 1'b0, 1'b0, 1'b0, 1'b0, QUAL_OFF, QUAL_OFF};

	// command register bits
	localparam int CMD_REARM = 0;
	localparam int CMD_BUSTRIG = 1;
	localparam int CMD_BLANK = 2;

	// timing, settings in 100 ns ticks
	localparam int CLK_PS = 40000;
	localparam int TICK_PS = 100000;
	localparam int TICK_X2_CYC = (2 * TICK_PS) / CLK_PS;
	localparam logic [31:0] DELAY_MIN_TICKS = 32'h0000_0002;
	localparam logic [31:0] DELAY_MAX_TICKS = 32'h00F4_2400;
	localparam logic [31:0] GATE_RESET_TICKS = 32'h001E_8480;

	// resolution: 250 ps rms, lsd may move 2.5 units
	localparam int QUANT_PS = 250;
	localparam int LSD_UNITS_X10 = 25;
	localparam int RES_STEP_PS = (QUANT_PS * 10) / LSD_UNITS_X10;
	localparam logic [63:0] CLK_RES_STEPS = 64'(CLK_PS / RES_STEP_PS);
	localparam logic [3:0] MAX_DIGITS = 4'hF;
	localparam logic [3:0] MAX_BLANK = 4'hA;
endpackage

// ===== mag_gate_ctrl.sv
`timescale 1ns/1ps
// Operation
// RL1: start and stop qualifier each set to rising, falling or off.
// RL2: enabled start qualifier ends free-run; each measurement waits for its edge.
// RL3: optional arming delay 200 ns to 1.6 s in 100 ns steps.
// RL4: start qualifier ignored for burst and pulse repetition functions.
// RL5: averaging with start qualifier gates only the first sample.
// RL6: enabled stop qualifier holds the measurement open until its edge.
// RL7: stop qualifier ignored for pulse width, duty, burst and repetition functions.
// RL8: both qualifiers make the external signal a gate; source places it.
// RL9: gate aligned to input triggers; free-run restarts after each result.
// RL10: start order: processed, one-shot hold, preparation, input trigger.
// RL11: averaging stops at first trigger after time; one-shot at next trigger.
// RL12: one-shot uses measuring time as hold; averaging as gate length.
// RL13: start also waits for rearm, bus trigger, qualifier edge, delay.
// RL14: stop also needs qualifier stop edge when stop qualifier selected.
// RL15: freeze mode arms one measurement per manual rearm request.
// RL16: frequency is cycles over actual gate time; rms error 250ps/gate.
// RL17: mantissa carried to as many as fifteen digits.
// RL18: truncate so quantization moves displayed lsd at most 2.5 units.
// RL19: suppression removes zero to ten trailing digits, same update rate.
// RL20: one press after all digits suppressed cancels suppression.
// RL21: qualifier synchronized, edge detected; delay counts 100 ns ticks.
module mag_gate_ctrl #(
	parameter int PROC_CYCLES = 16,
	parameter int PREP_CYCLES = 4,
	parameter int TMR_W = 36
) (
	input wire logic clk,
	input wire logic srst,
	input wire mag_pkg::mag_axi_req_s axi_req,
	output mag_pkg::mag_axi_rsp_s axi_rsp,
	input wire logic qual_in,
	input wire logic meas_in,
	output logic gate_open
);

	typedef enum logic [6:0] {
		ST_PROC = 7'h01,
		ST_HOLD = 7'h02,
		ST_PREP = 7'h04,
		ST_ARM = 7'h08,
		ST_DELAY = 7'h10,
		ST_TRIG = 7'h20,
		ST_COUNT = 7'h40
	} mag_state_e;

	mag_state_e state_q;
	mag_pkg::mag_ctrl_s ctrl_q;
	logic [31:0] delay_ticks_q;
	logic [31:0] gate_ticks_q;
	logic [TMR_W-1:0] tmr_q;
	logic [31:0] cyc_run_q;
	logic [31:0] clk_run_q;
	logic [31:0] cyc_res_q;
	logic [31:0] gtime_res_q;
	logic [7:0] res_seq_q;
	logic rearm_pend_q;
	logic bustrg_pend_q;
	logic stop_seen_q;
	logic [3:0] blank_q;
	logic [3:0] just_dig;
	logic [3:0] shown_dig;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic [2:0] qual_sync_q;
	logic [2:0] meas_sync_q;
	logic qual_lvl_q;
	logic meas_lvl_q;
	logic qual_chg;
	logic meas_rise;
	logic qual_rise;
	logic qual_fall;

	always_ff @(posedge clk) begin
		if (srst) begin
			qual_sync_q <= 3'h0;
			meas_sync_q <= 3'h0;
		end else begin
			qual_sync_q <= {qual_sync_q[1:0], qual_in};
			meas_sync_q <= {meas_sync_q[1:0], meas_in};
		end
	end

	// change counts once stages two and three agree
	// RL21: qualifier edge detect
	assign qual_chg = (qual_sync_q[1] == qual_sync_q[2]) && (qual_sync_q[2] != qual_lvl_q);
	assign qual_rise = qual_chg && qual_sync_q[2];
	assign qual_fall = qual_chg && !qual_sync_q[2];
	assign meas_rise = (meas_sync_q[1] == meas_sync_q[2]) && meas_sync_q[2] && !meas_lvl_q;

	always_ff @(posedge clk) begin
		if (srst) begin
			qual_lvl_q <= 1'b0;
			meas_lvl_q <= 1'b0;
		end else begin
			if (qual_sync_q[1] == qual_sync_q[2])
				qual_lvl_q <= qual_sync_q[2];
			if (meas_sync_q[1] == meas_sync_q[2])
				meas_lvl_q <= meas_sync_q[2];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// qualifier selection

	logic start_q_act;
	logic stop_q_act;
	logic start_edge;
	logic stop_edge;

	always_comb begin
		// RL4: no start qualifier for burst or prf
		start_q_act = (ctrl_q.start_qualify_setting != mag_pkg::QUAL_OFF)
			&& (ctrl_q.func != mag_pkg::FN_BURST) && (ctrl_q.func != mag_pkg::FN_PRF);
		// RL7: no stop qualifier for pw, duty, burst, prf
		stop_q_act = (ctrl_q.stop_qualify_setting != mag_pkg::QUAL_OFF)
			&& (ctrl_q.func != mag_pkg::FN_PWIDTH) && (ctrl_q.func != mag_pkg::FN_DUTY)
			&& (ctrl_q.func != mag_pkg::FN_BURST) && (ctrl_q.func != mag_pkg::FN_PRF);
		// RL1: independent edge choice
		start_edge = (ctrl_q.start_qualify_setting == mag_pkg::QUAL_RISE) ? qual_rise
			: (ctrl_q.start_qualify_setting == mag_pkg::QUAL_FALL) ? qual_fall : 1'b0;
		stop_edge = (ctrl_q.stop_qualify_setting == mag_pkg::QUAL_RISE) ? qual_rise
			: (ctrl_q.stop_qualify_setting == mag_pkg::QUAL_FALL) ? qual_fall : 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// bus slave

	logic aw_got_q;
	logic w_got_q;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic wr_fire;
	logic wr_ok;
	logic rd_fire;
	logic [31:0] rd_d;
	logic rd_ok;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		end
		return r;
	endfunction

	assign wr_fire = aw_got_q && w_got_q && !bvalid_q;
	assign wr_ok = (aw_addr_q == mag_pkg::OFS_CTRL) || (aw_addr_q == mag_pkg::OFS_DELAY)
		|| (aw_addr_q == mag_pkg::OFS_GATE) || (aw_addr_q == mag_pkg::OFS_CMD);
	assign rd_fire = axi_req.arvalid && !rvalid_q;

	always_comb begin
		axi_rsp.awready = !aw_got_q && !bvalid_q;
		axi_rsp.wready = !w_got_q && !bvalid_q;
		axi_rsp.bvalid = bvalid_q;
		axi_rsp.bresp = bresp_q;
		axi_rsp.arready = !rvalid_q;
		axi_rsp.rvalid = rvalid_q;
		axi_rsp.rdata = rdata_q;
		axi_rsp.rresp = rresp_q;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= mag_pkg::RESP_OKAY;
		end else begin
			if (axi_req.awvalid && !aw_got_q && !bvalid_q) begin
				aw_got_q <= 1'b1;
				aw_addr_q <= axi_req.awaddr;
			end
			if (axi_req.wvalid && !w_got_q && !bvalid_q) begin
				w_got_q <= 1'b1;
				w_data_q <= axi_req.wdata;
				w_strb_q <= axi_req.wstrb;
			end
			if (wr_fire) begin
				aw_got_q <= 1'b0;
				w_got_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_ok ? mag_pkg::RESP_OKAY : mag_pkg::RESP_SLVERR;
			end else if (bvalid_q && axi_req.bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	always_comb begin
		rd_ok = 1'b1;
		case (axi_req.araddr)
			mag_pkg::OFS_CTRL: rd_d = {21'h0, ctrl_q};
			mag_pkg::OFS_DELAY: rd_d = delay_ticks_q;
			mag_pkg::OFS_GATE: rd_d = gate_ticks_q;
			mag_pkg::OFS_CMD: rd_d = 32'h0000_0000;
			mag_pkg::OFS_STATUS: rd_d = {4'h0, res_seq_q, shown_dig, just_dig, blank_q,
				gate_open, state_q};
			mag_pkg::OFS_COUNT: rd_d = cyc_res_q;
			mag_pkg::OFS_GTIME: rd_d = gtime_res_q;
			default: begin
				rd_d = 32'h0000_0000;
				rd_ok = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= mag_pkg::RESP_OKAY;
		end else if (rd_fire) begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_d;
			rresp_q <= rd_ok ? mag_pkg::RESP_OKAY : mag_pkg::RESP_SLVERR;
		end else if (rvalid_q && axi_req.rready) begin
			rvalid_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// settings and commands

	logic [31:0] wdat;
	logic [31:0] ctrl_mrg;
	logic cmd_wr;
	logic arm_go;

	assign wdat = merge(32'h0000_0000, w_data_q, w_strb_q);
	assign ctrl_mrg = merge({21'h0, ctrl_q}, w_data_q, w_strb_q);
	assign cmd_wr = wr_fire && (aw_addr_q == mag_pkg::OFS_CMD);

	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl_q <= mag_pkg::CTRL_RESET;
			delay_ticks_q <= mag_pkg::DELAY_MIN_TICKS;
			gate_ticks_q <= mag_pkg::GATE_RESET_TICKS;
		end else if (wr_fire) begin
			if (aw_addr_q == mag_pkg::OFS_CTRL)
				ctrl_q <= mag_pkg::mag_ctrl_s'(ctrl_mrg[$bits(mag_pkg::mag_ctrl_s)-1:0]);
			// RL3: delay clamped to 200 ns .. 1.6 s
			if (aw_addr_q == mag_pkg::OFS_DELAY) begin
				if (merge(delay_ticks_q, w_data_q, w_strb_q) < mag_pkg::DELAY_MIN_TICKS)
					delay_ticks_q <= mag_pkg::DELAY_MIN_TICKS;
				else if (merge(delay_ticks_q, w_data_q, w_strb_q) > mag_pkg::DELAY_MAX_TICKS)
					delay_ticks_q <= mag_pkg::DELAY_MAX_TICKS;
				else
					delay_ticks_q <= merge(delay_ticks_q, w_data_q, w_strb_q);
			end
			if (aw_addr_q == mag_pkg::OFS_GATE)
				gate_ticks_q <= merge(gate_ticks_q, w_data_q, w_strb_q);
		end
	end

	// pending requests: a new request beats the clear on consumption
	always_ff @(posedge clk) begin
		if (srst) begin
			rearm_pend_q <= 1'b0;
			bustrg_pend_q <= 1'b0;
		end else begin
			if (cmd_wr && wdat[mag_pkg::CMD_REARM])
				rearm_pend_q <= 1'b1;
			else if (arm_go)
				rearm_pend_q <= 1'b0;
			if (cmd_wr && wdat[mag_pkg::CMD_BUSTRIG])
				bustrg_pend_q <= 1'b1;
			else if (arm_go)
				bustrg_pend_q <= 1'b0;
		end
	end

	// RL19: blanking steps independent of gate timing
	always_ff @(posedge clk) begin
		if (srst) begin
			blank_q <= 4'h0;
		end else if (cmd_wr && wdat[mag_pkg::CMD_BLANK]) begin
			// RL20: press after full blank cancels it
			if (blank_q >= mag_pkg::MAX_BLANK || blank_q >= just_dig)
				blank_q <= 4'h0;
			else
				blank_q <= blank_q + 4'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// gate sequencer

	logic [TMR_W-1:0] delay_cyc;
	logic [TMR_W-1:0] gate_cyc;
	logic tmr_done;
	logic stop_now;

	// 100 ns tick is 2.5 clocks; round up
	// RL21: delay in 100 ns ticks
	assign delay_cyc = TMR_W'((64'(delay_ticks_q) * 64'(mag_pkg::TICK_X2_CYC) + 64'h1) >> 1);
	assign gate_cyc = TMR_W'((64'(gate_ticks_q) * 64'(mag_pkg::TICK_X2_CYC) + 64'h1) >> 1);
	assign tmr_done = (tmr_q == '0);

	// RL13: all selected start conditions together
	// RL15: freeze waits for one rearm each
	// RL2: qualifier edge needed per measurement
	assign arm_go = (state_q == ST_ARM)
		&& (!ctrl_q.freeze || rearm_pend_q)
		&& (!ctrl_q.bus_trig_en || bustrg_pend_q)
		&& (!start_q_act || start_edge);

	// RL11: one-shot stops at next trigger, averaging after time
	// RL14: stop qualifier edge also required
	// RL8: both qualifiers form an external gate
	assign stop_now = meas_rise && (ctrl_q.single || tmr_done)
		&& (!stop_q_act || stop_seen_q || stop_edge);

	assign gate_open = (state_q == ST_COUNT);

	always_ff @(posedge clk) begin
		if (srst) begin
			state_q <= ST_PREP;
			tmr_q <= TMR_W'(PREP_CYCLES);
		end else begin
			case (state_q)
				// RL10: result processed first
				ST_PROC: begin
					if (tmr_done) begin
						// RL12: one-shot hold of measuring time
						state_q <= ctrl_q.single ? ST_HOLD : ST_PREP;
						tmr_q <= ctrl_q.single ? gate_cyc : TMR_W'(PREP_CYCLES);
					end else begin
						tmr_q <= tmr_q - 1'b1;
					end
				end
				ST_HOLD: begin
					if (tmr_done) begin
						state_q <= ST_PREP;
						tmr_q <= TMR_W'(PREP_CYCLES);
					end else begin
						tmr_q <= tmr_q - 1'b1;
					end
				end
				ST_PREP: begin
					if (tmr_done)
						state_q <= ST_ARM;
					else
						tmr_q <= tmr_q - 1'b1;
				end
				ST_ARM: begin
					if (arm_go) begin
						// RL3: delay from qualifier edge
						// RL21: counter starts on the detected edge
						if (ctrl_q.delay_en && start_q_act) begin
							state_q <= ST_DELAY;
							tmr_q <= delay_cyc - 1'b1;
						end else begin
							state_q <= ST_TRIG;
						end
					end
				end
				ST_DELAY: begin
					if (tmr_done)
						state_q <= ST_TRIG;
					else
						tmr_q <= tmr_q - 1'b1;
				end
				// RL9: gate opens on an input trigger
				ST_TRIG: begin
					if (meas_rise) begin
						state_q <= ST_COUNT;
						tmr_q <= gate_cyc;
					end
				end
				// RL5: averaged samples run on without qualifier
				ST_COUNT: begin
					if (stop_now) begin
						// RL9: free-run restarts via processing
						state_q <= ST_PROC;
						tmr_q <= TMR_W'(PROC_CYCLES);
					end else if (!tmr_done) begin
						tmr_q <= tmr_q - 1'b1;
					end
				end
				default: begin
					state_q <= ST_PREP;
					tmr_q <= TMR_W'(PREP_CYCLES);
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// counting and results

	// RL6: stop edge remembered while the gate is open
	always_ff @(posedge clk) begin
		if (srst)
			stop_seen_q <= 1'b0;
		else if (state_q != ST_COUNT)
			stop_seen_q <= 1'b0;
		else if (stop_edge)
			stop_seen_q <= 1'b1;
	end

	// RL16: cycles and actual gate time kept for n over tg
	always_ff @(posedge clk) begin
		if (srst) begin
			cyc_run_q <= 32'h0000_0000;
			clk_run_q <= 32'h0000_0000;
			cyc_res_q <= 32'h0000_0000;
			gtime_res_q <= 32'h0000_0000;
			res_seq_q <= 8'h00;
		end else if (state_q == ST_TRIG) begin
			cyc_run_q <= 32'h0000_0000;
			clk_run_q <= 32'h0000_0000;
		end else if (state_q == ST_COUNT) begin
			clk_run_q <= clk_run_q + 32'h1;
			if (stop_now) begin
				cyc_res_q <= cyc_run_q + 32'h1;
				gtime_res_q <= clk_run_q + 32'h1;
				res_seq_q <= res_seq_q + 8'h01;
			end else if (meas_rise) begin
				cyc_run_q <= cyc_run_q + 32'h1;
			end
		end
	end

	// digits justified by gate time: 10^k steps of 100 ps
	always_comb begin
		logic [63:0] steps;
		logic [63:0] p;
		steps = 64'(gtime_res_q) * mag_pkg::CLK_RES_STEPS;
		p = 64'h1;
		just_dig = 4'h0;
		// RL17: up to fifteen digits
		// RL18: lsd moves at most 2.5 units
		for (int k = 1; k <= 15; k++) begin
			p = p * 64'hA;
			if (steps >= p)
				just_dig = 4'(k);
		end
		if (just_dig > mag_pkg::MAX_DIGITS)
			just_dig = mag_pkg::MAX_DIGITS;
	end

	// RL19: suppressed digits taken from justified count
	assign shown_dig = (blank_q >= just_dig) ? 4'h0 : just_dig - blank_q;

endmodule // mag_gate_ctrl

// ===== mag_gate_ctrl_sva.sv
`timescale 1ns/1ps
module mag_gate_ctrl_sva #(
	parameter int PROC_CYCLES = 16,
	parameter int PREP_CYCLES = 4,
	parameter int TMR_W = 36
) (
	input wire logic clk,
	input wire logic srst,
	input wire mag_pkg::mag_axi_req_s axi_req,
	input wire mag_pkg::mag_axi_rsp_s axi_rsp,
	input wire logic qual_in,
	input wire logic meas_in,
	input wire logic gate_open
);
	// cycles since the last rising pin change, saturating
	logic meas_q;
	logic [3:0] since_q;
	always_ff @(posedge clk) begin
		meas_q <= meas_in;
		if (srst) begin
			since_q <= 4'hF;
		end else if (meas_in && !meas_q) begin
			since_q <= 4'h0;
		end else if (since_q != 4'hF) begin
			since_q <= since_q + 4'h1;
		end
	end
	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	sequence ar_taken;
		axi_req.arvalid && axi_rsp.arready;
	endsequence
	sequence w_taken;
		axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
	endsequence
	rd_answer_a: assert property (ar_taken |=> axi_rsp.rvalid)
		else $error("read answer late");
	wr_answer_a: assert property (w_taken |-> ##[1:2] axi_rsp.bvalid)
		else $error("write answer late");
	b_hold_a: assert property (axi_rsp.bvalid && !axi_req.bready |=>
		axi_rsp.bvalid && $stable(axi_rsp.bresp)) else $error("write answer dropped");
	r_hold_a: assert property (axi_rsp.rvalid && !axi_req.rready |=>
		axi_rsp.rvalid && $stable(axi_rsp.rdata)) else $error("read answer dropped");
	ar_block_a: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
		else $error("read taken while answering");
	aw_block_a: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
		else $error("write taken while answering");
	open_trig_a: assert property ($rose(gate_open) |-> since_q <= 4'h8)
		else $error("gate opened without input trigger");
	close_trig_a: assert property ($fell(gate_open) |-> since_q <= 4'h8)
		else $error("gate closed without input trigger");
	rest_gap_a: assert property ($fell(gate_open) |=> !gate_open [*8])
		else $error("gate reopened before processing");
	reset_idle_a: assert property (disable iff (1'b0) srst |=>
		!gate_open && !axi_rsp.bvalid && !axi_rsp.rvalid) else $error("reset not idle");
endmodule // mag_gate_ctrl_sva

bind mag_gate_ctrl mag_gate_ctrl_sva #(.PROC_CYCLES(PROC_CYCLES), .PREP_CYCLES(PREP_CYCLES),
	.TMR_W(TMR_W)) i_mag_gate_ctrl_sva (.clk(clk), .srst(srst), .axi_req(axi_req),
	.axi_rsp(axi_rsp), .qual_in(qual_in), .meas_in(meas_in), .gate_open(gate_open));

// ===== mag_sync_src.sv
`timescale 1ns/1ps
module mag_sync_src (
	input wire logic clk,
	input wire logic run,
	input wire logic qual_req,
	output logic meas_in,
	output logic qual_in
);
	logic [3:0] ph_q = 4'h0;
	logic [4:0] ql_q = 5'h0;
	initial meas_in = 1'b0;
	initial qual_in = 1'b0;
	// measured input, ten clocks per period while running
	always @(posedge clk) begin
		ph_q <= (ph_q == 4'h4) ? 4'h0 : ph_q + 4'h1;
		if (ph_q == 4'h4) meas_in <= run & ~meas_in;
	end
	always @(posedge clk) begin
		ql_q <= qual_req ? 5'h10 : (ql_q != 5'h0 ? ql_q - 5'h1 : ql_q);
		qual_in <= (ql_q != 5'h0);
	end
endmodule // mag_sync_src

// ===== mag_gate_ctrl_tb_top.sv
`timescale 1ns/1ps
module mag_gate_ctrl_tb_top;
	typedef struct packed {
		logic [7:0] a;
		logic [31:0] d;
		logic [31:0] e;
		logic [1:0] r;
	} mag_row_s;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic run = 1'b0;
	logic qual_req = 1'b0;
	logic meas_in;
	logic qual_in;
	logic gate_open;
	mag_pkg::mag_axi_req_s req = '0;
	mag_pkg::mag_axi_rsp_s rsp;
	int mismatches = 0;
	int tests_run = 0;
	int rises = 0;
	int r0 = 0;
	int low_c = 0;
	int last_gap = 0;
	logic g_q = 1'b0;
	logic [31:0] rd;
	logic [31:0] gt;
	logic [1:0] rr;
	mag_row_s rows [7] = '{
		'{8'h00, 32'h0000_04AA, 32'h0000_04AA, 2'h0},
		'{8'h04, 32'h0000_0000, 32'h0000_0002, 2'h0},
		'{8'h04, 32'hFFFF_FFFF, 32'h00F4_2400, 2'h0},
		'{8'h04, 32'h0000_0003, 32'h0000_0003, 2'h0},
		'{8'h08, 32'h0000_0004, 32'h0000_0004, 2'h0},
		'{8'h0C, 32'h0000_0000, 32'h0000_0000, 2'h0},
		'{8'h1C, 32'h0000_0055, 32'h0000_0000, 2'h2}};
	always #20 clk = ~clk;
	mag_gate_ctrl i_mag_gate_ctrl (.clk(clk), .srst(srst), .axi_req(req), .axi_rsp(rsp),
		.qual_in(qual_in), .meas_in(meas_in), .gate_open(gate_open));
	mag_sync_src i_mag_sync_src (.clk(clk), .run(run), .qual_req(qual_req),
		.meas_in(meas_in), .qual_in(qual_in));
	// sampled mid-cycle so design updates have landed
	always @(negedge clk) begin
		g_q <= gate_open;
		if (gate_open === 1'b1 && g_q !== 1'b1) begin
			rises++;
			last_gap = low_c;
		end
		low_c = (gate_open === 1'b1) ? 0 : low_c + 1;
	end
	////////////////////////////////////////////////////////////////
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic idle(input int c);
		repeat (c) @(posedge clk);
	endtask
	task automatic cnt(input int e);
		chk(32'(rises - r0), 32'(e));
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		req.awaddr <= a;
		req.wdata <= d;
		req.wstrb <= 4'hF;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		do begin
			@(posedge clk);
			if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
			if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
		end while (rsp.bvalid !== 1'b1);
		r = rsp.bresp;
		req.bready <= 1'b0;
	endtask
	task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		req.araddr <= a;
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		do begin
			@(posedge clk);
			if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
		end while (rsp.rvalid !== 1'b1);
		d = rsp.rdata;
		r = rsp.rresp;
		req.rready <= 1'b0;
	endtask
	task automatic w(input logic [7:0] a, input logic [31:0] d);
		wr(a, d, rr);
	endtask
	task automatic pulse;
		qual_req <= 1'b1;
		@(posedge clk);
		qual_req <= 1'b0;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		idle(20000);
		mismatches++;
		close_out;
	end
	initial begin
		idle(20);
		srst <= 1'b0;
		rdr(mag_pkg::OFS_CTRL, rd, rr);
		chk(rd, 32'h0000_0000);
		rdr(mag_pkg::OFS_DELAY, rd, rr);
		chk(rd, 32'h0000_0002);
		rdr(mag_pkg::OFS_GATE, rd, rr);
		chk(rd, 32'h001E_8480);
		chk(32'(gate_open), 32'h0);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d, rr);
			chk(32'(rr), 32'(rows[i].r));
			rdr(rows[i].a, rd, rr);
			chk(rd, rows[i].e);
			chk(32'(rr), 32'(rows[i].r));
		end
		w(mag_pkg::OFS_GATE, 32'h0000_0028);
		w(mag_pkg::OFS_CTRL, 32'h0000_0000);
		run <= 1'b1;
		idle(200);
		r0 = rises;
		idle(600);
		chk(32'(rises - r0 >= 3), 32'h1);
		chk(32'(last_gap <= 60), 32'h1);
		w(mag_pkg::OFS_CTRL, 32'h0000_0040);
		idle(200);
		rdr(mag_pkg::OFS_GTIME, gt, rr);
		chk(32'(gt >= 100 && gt <= 112), 32'h1);
		rdr(mag_pkg::OFS_COUNT, rd, rr);
		chk(32'(rd >= 10 && rd <= 12), 32'h1);
		rdr(mag_pkg::OFS_STATUS, rd, rr);
		chk(32'(rd[15:12]), 32'h4);
		for (int i = 1; i <= 5; i++) begin
			w(mag_pkg::OFS_CMD, 32'h0000_0004);
			rdr(mag_pkg::OFS_STATUS, rd, rr);
			chk(32'(rd[11:8]), 32'(i % 5));
		end
		for (int k = 0; k < 2; k++) begin
			w(mag_pkg::OFS_CTRL, k ? 32'h0000_0080 : 32'h0000_0040);
			idle(300);
			r0 = rises;
			idle(300);
			cnt(0);
			w(mag_pkg::OFS_CMD, k ? 32'h0000_0002 : 32'h0000_0001);
			idle(400);
			cnt(1);
		end
		w(mag_pkg::OFS_CTRL, 32'h0000_0020);
		idle(800);
		chk(32'(last_gap >= 100), 32'h1);
		rdr(mag_pkg::OFS_GTIME, gt, rr);
		chk(32'(gt <= 12), 32'h1);
		w(mag_pkg::OFS_CTRL, 32'h0000_0001);
		idle(300);
		r0 = rises;
		idle(300);
		cnt(0);
		pulse;
		idle(100);
		cnt(1);
		idle(300);
		cnt(1);
		w(mag_pkg::OFS_CTRL, 32'h0000_0401);
		r0 = rises;
		idle(400);
		chk(32'(rises - r0 >= 2), 32'h1);
		w(mag_pkg::OFS_CTRL, 32'h0000_0011);
		w(mag_pkg::OFS_DELAY, 32'h0000_0064);
		idle(300);
		r0 = rises;
		pulse;
		idle(200);
		cnt(0);
		idle(150);
		cnt(1);
		// let the delayed gate finish before stop qualifying
		idle(100);
		w(mag_pkg::OFS_CTRL, 32'h0000_0005);
		idle(400);
		pulse;
		idle(300);
		chk(32'(gate_open), 32'h1);
		pulse;
		idle(60);
		chk(32'(gate_open), 32'h0);
		w(mag_pkg::OFS_CTRL, 32'h0000_0204);
		r0 = rises;
		idle(500);
		chk(32'(rises - r0 >= 2), 32'h1);
		// falling start edge: rise alone must leave it armed
		w(mag_pkg::OFS_CTRL, 32'h0000_0002);
		idle(300);
		r0 = rises;
		pulse;
		idle(10);
		rdr(mag_pkg::OFS_STATUS, rd, rr);
		chk(32'(rd[6:0]), 32'h8);
		idle(100);
		cnt(1);
		// mid-run reset
		srst <= 1'b1;
		idle(3);
		srst <= 1'b0;
		rdr(mag_pkg::OFS_CTRL, rd, rr);
		chk(rd, 32'h0000_0000);
		chk(32'(gate_open), 32'h0);
		close_out;
	end
endmodule // mag_gate_ctrl_tb_top
